// file: hw/pmc_pkg.sv
// power mode controller package: power states, field widths, reset values
// assumes: used by pmc_top and pmc_lvd through pmc_pkg::name, never imported
package pmc_pkg;

  // ----------------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_SLEEP
  } pmc_state_t;

  // ----------------------------------------------------------------------
  // field widths and encodings
  // ----------------------------------------------------------------------
  localparam int         LVD_TAPS      = 16;   // software trip points
  localparam int         LVD_SEL_W     = 4;
  localparam int         CLK_SRC_W     = 3;
  localparam logic       SAVE_SEL_SLEEP = 1'h0; // operand of power-save instruction
  localparam logic       SAVE_SEL_IDLE  = 1'h1;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [CLK_SRC_W-1:0] CLK_SRC_RST = 3'h0;
  localparam logic [1:0]           STATE_CODE_RUN   = 2'h0;
  localparam logic [1:0]           STATE_CODE_IDLE  = 2'h1;
  localparam logic [1:0]           STATE_CODE_SLEEP = 2'h2;

endpackage : pmc_pkg

// file: hw/pmc_lvd.sv
// low-voltage detector: tap select, enable gate and sticky interrupt flag
// assumes: comparator results arrive synchronous to sys_clk, one per tap
`timescale 1ns/1ns
module pmc_lvd #(
  parameter int TAPS  = pmc_pkg::LVD_TAPS,
  parameter int SEL_W = pmc_pkg::LVD_SEL_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             lvd_en,
  input  wire logic [SEL_W-1:0] lvd_tap_sel,
  input  wire logic             lvd_ext_sel,
  input  wire logic [TAPS-1:0]  lvd_tap_below,
  input  wire logic             low_voltage_external_input,
  input  wire logic             lvd_flag_clr,
  output logic                  lvd_active_q,
  output logic                  lvd_flag_q
);

  logic below;
  logic lvd_active_d;
  logic lvd_flag_d;

  // ----------------------------------------------------------------------
  // comparator select and flag
  // ----------------------------------------------------------------------
  // power state is not an input: the detector works in sleep too
  always_comb begin
    below        = lvd_ext_sel ? low_voltage_external_input : lvd_tap_below[lvd_tap_sel];
    lvd_active_d = lvd_en;
    lvd_flag_d   = lvd_flag_q;
    if (lvd_flag_clr) begin
      lvd_flag_d = 1'b0;
    end
    // set beats a clear in the same cycle
    if (lvd_en && below) begin
      lvd_flag_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvd_active_q <= 1'b0;
      lvd_flag_q   <= 1'b0;
    end else begin
      lvd_active_q <= lvd_active_d;
      lvd_flag_q   <= lvd_flag_d;
    end
  end

  // a qualified comparator result must set the flag, even against a clear
  property p_lvd_set;
    @(posedge sys_clk) disable iff (!rst_n)
      (lvd_en && below) |=> lvd_flag_q;
  endproperty
  a_lvd_set: assert property (p_lvd_set) else $error("low-voltage flag not set");

endmodule : pmc_lvd

// file: hw/pmc_top.sv
// power mode controller: run, idle and sleep, clock source, wake, watchdog
// assumes: all inputs synchronous to sys_clk; rst_n is the merged device reset
`timescale 1ns/1ns
module pmc_top #(
  parameter int PERIPH_N = 8
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic                           power_save_instruction,
  input  wire logic                           power_save_sel,
  input  wire logic                           irq_pending,
  input  wire logic                           wdt_en,
  input  wire logic                           wdt_timeout,
  input  wire logic                           fail_safe_clock_monitor_en,
  input  wire logic                           bor_en,
  input  wire logic                           bor_trip,
  input  wire logic [pmc_pkg::CLK_SRC_W-1:0]  cfg_clk_src,
  input  wire logic                           clk_switch_req,
  input  wire logic [pmc_pkg::CLK_SRC_W-1:0]  clk_switch_sel,
  input  wire logic [PERIPH_N-1:0]            stop_in_idle,
  input  wire logic [PERIPH_N-1:0]            periph_ext_clk,
  input  wire logic                           lvd_en,
  input  wire logic [pmc_pkg::LVD_SEL_W-1:0]  lvd_tap_sel,
  input  wire logic                           lvd_ext_sel,
  input  wire logic [pmc_pkg::LVD_TAPS-1:0]   lvd_tap_below,
  input  wire logic                           low_voltage_external_input,
  input  wire logic                           lvd_flag_clr,
  output logic [1:0]                          power_state_q,
  output logic                                cpu_run_q,
  output logic                                sysclk_osc_en_q,
  output logic                                fail_safe_clock_monitor_active_q,
  output logic                                low_power_rc_oscillator_en_q,
  output logic                                bor_active_q,
  output logic                                bor_reset_q,
  output logic                                wdt_clear_q,
  output logic                                wdt_reset_q,
  output logic                                wake_q,
  output logic [PERIPH_N-1:0]                 periph_clk_en_q,
  output logic [pmc_pkg::CLK_SRC_W-1:0]       clk_src_q,
  output logic                                lvd_active_q,
  output logic                                lvd_flag_q
);

  // ----------------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------------
  pmc_pkg::pmc_state_t              state_q;
  pmc_pkg::pmc_state_t              state_d;
  logic [1:0]                       power_state_d;
  logic                             cpu_run_d;
  logic                             sysclk_osc_en_d;
  logic                             fail_safe_clock_monitor_active_d;
  logic                             low_power_rc_oscillator_en_d;
  logic                             bor_active_d;
  logic                             bor_reset_d;
  logic                             wdt_clear_d;
  logic                             wdt_reset_d;
  logic                             wake_d;
  logic [PERIPH_N-1:0]              periph_clk_en_d;
  logic [pmc_pkg::CLK_SRC_W-1:0]    clk_src_d;
  logic                             src_loaded_q;
  logic                             src_loaded_d;
  logic                             wake_any;

  // state code seen by the core and the clock gates
  function automatic logic [1:0] state_code(input pmc_pkg::pmc_state_t s);
    unique case (s)
      pmc_pkg::PMC_RUN:   state_code = pmc_pkg::STATE_CODE_RUN;
      pmc_pkg::PMC_IDLE:  state_code = pmc_pkg::STATE_CODE_IDLE;
      pmc_pkg::PMC_SLEEP: state_code = pmc_pkg::STATE_CODE_SLEEP;
      default:            state_code = pmc_pkg::STATE_CODE_RUN;
    endcase
  endfunction : state_code

  // ----------------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------------
  // wake sources sampled as levels; resets arrive through rst_n itself
  always_comb begin
    wake_any    = irq_pending || wdt_timeout;
    state_d     = state_q;
    wdt_clear_d = 1'b0;
    wdt_reset_d = 1'b0;
    wake_d      = 1'b0;
    unique case (state_q)
      pmc_pkg::PMC_RUN: begin
        wdt_reset_d = wdt_timeout;
        // a pending wake cancels the request, else the core would stall unserviced
        if (power_save_instruction && !wake_any) begin
          if (power_save_sel == pmc_pkg::SAVE_SEL_SLEEP) begin
            state_d     = pmc_pkg::PMC_SLEEP;
            wdt_clear_d = wdt_en;
          end else begin
            state_d     = pmc_pkg::PMC_IDLE;
            wdt_clear_d = 1'b1;
          end
        end
      end
      pmc_pkg::PMC_IDLE: begin
        wdt_reset_d = wdt_timeout;
        if (wake_any) begin
          state_d = pmc_pkg::PMC_RUN;
          wake_d  = 1'b1;
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        // time-out only wakes here, no reset
        if (wake_any) begin
          state_d = pmc_pkg::PMC_RUN;
          wake_d  = 1'b1;
        end
      end
      // illegal code: fall back to run rather than lock up
      default: state_d = pmc_pkg::PMC_RUN;
    endcase
  end

  // ----------------------------------------------------------------------
  // clock and analog enables, derived from the next state except brown-out, which follows bor_en and bor_trip only
  // ----------------------------------------------------------------------
  // outputs follow state_d so they change on the same edge as the state
  always_comb begin
    power_state_d   = state_code(state_d);
    cpu_run_d       = (state_d == pmc_pkg::PMC_RUN);
    sysclk_osc_en_d = (state_d != pmc_pkg::PMC_SLEEP);
    fail_safe_clock_monitor_active_d = fail_safe_clock_monitor_en && (state_d != pmc_pkg::PMC_SLEEP);
    if (state_d == pmc_pkg::PMC_SLEEP) begin
      low_power_rc_oscillator_en_d = wdt_en;
    end else begin
      low_power_rc_oscillator_en_d = wdt_en || fail_safe_clock_monitor_en;
    end
    bor_active_d = bor_en;
    bor_reset_d  = bor_en && bor_trip;
  end

  // per-peripheral clock gates
  generate
    for (genvar i = 0; i < PERIPH_N; i++) begin : g_gate
      always_comb begin
        unique case (state_d)
          pmc_pkg::PMC_RUN:   periph_clk_en_d[i] = 1'b1;
          pmc_pkg::PMC_IDLE:  periph_clk_en_d[i] = !stop_in_idle[i];
          pmc_pkg::PMC_SLEEP: periph_clk_en_d[i] = periph_ext_clk[i];
          default:            periph_clk_en_d[i] = 1'b1;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------------
  // async reset may only load a constant, so the config bits are taken
  // on the first edge after release
  always_comb begin
    src_loaded_d = 1'b1;
    clk_src_d    = clk_src_q;
    if (!src_loaded_q) begin
      clk_src_d = cfg_clk_src;
    end else if (clk_switch_req && state_q == pmc_pkg::PMC_RUN) begin
      clk_src_d = clk_switch_sel;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= pmc_pkg::PMC_RUN;
      power_state_q   <= pmc_pkg::STATE_CODE_RUN;
      cpu_run_q       <= 1'b1;
      sysclk_osc_en_q <= 1'b1;
      fail_safe_clock_monitor_active_q <= 1'b0;
      low_power_rc_oscillator_en_q     <= 1'b0;
      bor_active_q    <= 1'b0;
      bor_reset_q     <= 1'b0;
      wdt_clear_q     <= 1'b0;
      wdt_reset_q     <= 1'b0;
      wake_q          <= 1'b0;
      periph_clk_en_q <= '0;
      clk_src_q       <= pmc_pkg::CLK_SRC_RST;
      src_loaded_q    <= 1'b0;
    end else begin
      state_q         <= state_d;
      power_state_q   <= power_state_d;
      cpu_run_q       <= cpu_run_d;
      sysclk_osc_en_q <= sysclk_osc_en_d;
      fail_safe_clock_monitor_active_q <= fail_safe_clock_monitor_active_d;
      low_power_rc_oscillator_en_q     <= low_power_rc_oscillator_en_d;
      bor_active_q    <= bor_active_d;
      bor_reset_q     <= bor_reset_d;
      wdt_clear_q     <= wdt_clear_d;
      wdt_reset_q     <= wdt_reset_d;
      wake_q          <= wake_d;
      periph_clk_en_q <= periph_clk_en_d;
      clk_src_q       <= clk_src_d;
      src_loaded_q    <= src_loaded_d;
    end
  end

  // ----------------------------------------------------------------------
  // low-voltage detector
  // ----------------------------------------------------------------------
  pmc_lvd #(
    .TAPS  (pmc_pkg::LVD_TAPS),
    .SEL_W (pmc_pkg::LVD_SEL_W)
  ) u_lvd (
    .sys_clk                    (sys_clk),
    .rst_n                      (rst_n),
    .lvd_en                     (lvd_en),
    .lvd_tap_sel                (lvd_tap_sel),
    .lvd_ext_sel                (lvd_ext_sel),
    .lvd_tap_below              (lvd_tap_below),
    .low_voltage_external_input (low_voltage_external_input),
    .lvd_flag_clr               (lvd_flag_clr),
    .lvd_active_q               (lvd_active_q),
    .lvd_flag_q                 (lvd_flag_q)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_sleep_req;
    state_q == pmc_pkg::PMC_RUN && power_save_instruction && !irq_pending && !wdt_timeout
      && power_save_sel == pmc_pkg::SAVE_SEL_SLEEP;
  endsequence

  sequence s_idle_req;
    state_q == pmc_pkg::PMC_RUN && power_save_instruction && !irq_pending && !wdt_timeout
      && power_save_sel == pmc_pkg::SAVE_SEL_IDLE;
  endsequence

  property p_sleep_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      s_sleep_req |=> state_q == pmc_pkg::PMC_SLEEP && !sysclk_osc_en_q && !cpu_run_q
        && wdt_clear_q == $past(wdt_en);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_idle_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      s_idle_req |=> state_q == pmc_pkg::PMC_IDLE && sysclk_osc_en_q && !cpu_run_q && wdt_clear_q;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

  property p_only_by_instr;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == pmc_pkg::PMC_RUN && !power_save_instruction) |=> state_q == pmc_pkg::PMC_RUN;
  endproperty
  a_only_by_instr: assert property (p_only_by_instr) else $error("low power without instruction");

  property p_wake_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == pmc_pkg::PMC_RUN && power_save_instruction && (irq_pending || wdt_timeout))
        |=> state_q == pmc_pkg::PMC_RUN && cpu_run_q;
  endproperty
  a_wake_wins: assert property (p_wake_wins) else $error("wake lost to power-save");

  property p_wake_exit;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q != pmc_pkg::PMC_RUN && (irq_pending || wdt_timeout))
        |=> cpu_run_q && wake_q && power_state_q == pmc_pkg::STATE_CODE_RUN;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("no wake from low power");

  property p_wdt_sleep;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == pmc_pkg::PMC_SLEEP && wdt_timeout) |=> !wdt_reset_q ##1 !wdt_reset_q;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("time-out reset in sleep");

  property p_wdt_run;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q != pmc_pkg::PMC_SLEEP && wdt_timeout) |=> wdt_reset_q;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("time-out reset missing");

  property p_sleep_gates;
    @(posedge sys_clk) disable iff (!rst_n)
      state_q == pmc_pkg::PMC_SLEEP |-> !fail_safe_clock_monitor_active_q
        && low_power_rc_oscillator_en_q == $past(wdt_en) && periph_clk_en_q == $past(periph_ext_clk);
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("sleep gating wrong");

  property p_idle_gates;
    @(posedge sys_clk) disable iff (!rst_n)
      state_q == pmc_pkg::PMC_IDLE |-> periph_clk_en_q == ~$past(stop_in_idle)
        && low_power_rc_oscillator_en_q == ($past(wdt_en) || $past(fail_safe_clock_monitor_en));
  endproperty
  a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");

  property p_bor;
    @(posedge sys_clk) disable iff (!rst_n)
      (bor_en && bor_trip) |=> bor_reset_q && bor_active_q;
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out reset missing");

  property p_src_load;
    @(posedge sys_clk) disable iff (!rst_n)
      !src_loaded_q |=> clk_src_q == $past(cfg_clk_src);
  endproperty
  a_src_load: assert property (p_src_load) else $error("config clock source not loaded");

endmodule : pmc_top

// file: tb/pmc_core_model.sv
// partner model: processor core issuing the power-save instruction, plus interrupt logic
// assumes: bench commands change just after the rising edge of sys_clk
`timescale 1ns/1ns
module pmc_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_run_q,
  input  wire logic       cmd_save,
  input  wire logic       cmd_sel,
  input  wire logic       cmd_irq,
  input  wire logic [3:0] irq_delay,
  output logic            power_save_instruction,
  output logic            power_save_sel,
  output logic            irq_pending
);
  logic [3:0] dly_q;

  // a halted core executes nothing; operand toggles outside the pulse so stale values are not trusted
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_save_instruction <= 1'h0;
      power_save_sel         <= 1'h0;
      irq_pending            <= 1'h0;
      dly_q                  <= 4'h0;
    end else begin
      power_save_instruction <= cmd_save && cpu_run_q;
      power_save_sel         <= cmd_save ? cmd_sel : ~power_save_sel;
      dly_q                  <= !cmd_irq ? 4'h0 : (dly_q == irq_delay) ? dly_q : dly_q + 4'h1;
      irq_pending            <= cmd_irq && (dly_q == irq_delay); // prompt or slow request
    end
  end
endmodule : pmc_core_model

// file: tb/tb.sv
// testbench for the power mode controller: run, idle, sleep, wake, clock source, lvd
// assumes: pmc_top with default PERIPH_N of 8, core model drives the instruction and irq
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [1:0] st;
    logic       cpu, osc, mon, rco, wclr, wake;
    logic [7:0] per;
  } pmc_exp_t;

  logic        sys_clk = 1'h0, rst_n, cmd_save, cmd_sel, cmd_irq, power_save_instruction, power_save_sel;
  logic        irq_pending, wdt_en, wdt_timeout, fail_safe_clock_monitor_en, bor_en, bor_trip, lvd_en;
  logic        clk_switch_req, fail_safe_clock_monitor_active_q, low_power_rc_oscillator_en_q;
  logic        lvd_ext_sel, low_voltage_external_input, lvd_flag_clr, cpu_run_q, sysclk_osc_en_q;
  logic        bor_active_q, bor_reset_q, wdt_clear_q, wdt_reset_q, wake_q;
  logic        lvd_active_q, lvd_flag_q;
  logic [1:0]  power_state_q, prev_st;
  logic [2:0]  cfg_clk_src, clk_switch_sel, clk_src_q, old_src;
  logic [3:0]  irq_delay, lvd_tap_sel;
  logic [7:0]  stop_in_idle, periph_ext_clk, periph_clk_en_q;
  logic [15:0] lvd_tap_below;
  int          error_cnt = 0, num_checks = 0, cyc_cnt = 0;
  pmc_exp_t    exp_q[$];
  pmc_exp_t    e;

  pmc_top pmc_top_inst (.sys_clk, .rst_n, .power_save_instruction, .power_save_sel, .irq_pending,
    .wdt_en, .wdt_timeout, .fail_safe_clock_monitor_en, .bor_en, .bor_trip, .cfg_clk_src,
    .clk_switch_req, .clk_switch_sel, .stop_in_idle, .periph_ext_clk, .lvd_en, .lvd_tap_sel, .lvd_ext_sel,
    .lvd_tap_below, .low_voltage_external_input, .lvd_flag_clr, .power_state_q, .cpu_run_q, .sysclk_osc_en_q,
    .fail_safe_clock_monitor_active_q, .low_power_rc_oscillator_en_q, .bor_active_q, .bor_reset_q,
    .wdt_clear_q, .wdt_reset_q, .wake_q, .periph_clk_en_q, .clk_src_q, .lvd_active_q, .lvd_flag_q);
  pmc_core_model pmc_core_model_inst (.sys_clk, .rst_n, .cpu_run_q, .cmd_save, .cmd_sel, .cmd_irq,
    .irq_delay, .power_save_instruction, .power_save_sel, .irq_pending);

  always #4 sys_clk = ~sys_clk; // 125 MHz

  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // scoreboard: every change of power state takes the oldest note
  always @(negedge sys_clk) begin
    if (rst_n && power_state_q !== prev_st) begin
      if (exp_q.size() == 0) chk(16'(power_state_q), 16'(prev_st));
      else begin
        e = exp_q.pop_front();
        chk(16'(power_state_q), 16'(e.st));
        chk(16'(cpu_run_q), 16'(e.cpu));
        chk(16'(sysclk_osc_en_q), 16'(e.osc));
        chk(16'(fail_safe_clock_monitor_active_q), 16'(e.mon));
        if (e.st !== pmc_pkg::STATE_CODE_RUN) begin
          chk(16'(low_power_rc_oscillator_en_q), 16'(e.rco));
        end
        chk(16'(wdt_clear_q), 16'(e.wclr));
        chk(16'(wake_q), 16'(e.wake));
        chk(16'(periph_clk_en_q), 16'(e.per));
      end
    end
    prev_st = power_state_q;
  end

  // ----------------------------------------------------------------------
  // stimulus tasks, all changes one ns after the rising edge
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wait_state(input logic [1:0] want);
    int n;
    n = 0;
    while (power_state_q !== want && n < 40) begin
      cyc(1);
      n++;
    end
    chk(16'(power_state_q), 16'(want));
  endtask : wait_state

  task automatic enter(input logic idle);
    exp_q.push_back(pmc_exp_t'{idle ? pmc_pkg::STATE_CODE_IDLE : pmc_pkg::STATE_CODE_SLEEP, 1'h0, idle,
      idle & fail_safe_clock_monitor_en, idle ? (wdt_en | fail_safe_clock_monitor_en) : wdt_en, idle | wdt_en,
      1'h0, idle ? ~stop_in_idle : periph_ext_clk});
    cmd_sel  = idle ? pmc_pkg::SAVE_SEL_IDLE : pmc_pkg::SAVE_SEL_SLEEP;
    cmd_save = 1'h1;
    cyc(1);
    cmd_save = 1'h0;
    wait_state(idle ? pmc_pkg::STATE_CODE_IDLE : pmc_pkg::STATE_CODE_SLEEP);
  endtask : enter

  // time-out resets only when it wakes from idle, never from sleep
  task automatic wake(input logic by_wdt, input logic idle);
    exp_q.push_back(pmc_exp_t'{pmc_pkg::STATE_CODE_RUN, 1'h1, 1'h1, fail_safe_clock_monitor_en,
      1'h0, 1'h0, 1'h1, 8'hFF});
    if (by_wdt) begin
      wdt_timeout = 1'h1;
      cyc(1);
      wdt_timeout = 1'h0;
    end else begin
      irq_delay = 4'($urandom);
      cmd_irq   = 1'h1;
    end
    wait_state(pmc_pkg::STATE_CODE_RUN);
    chk(16'(wdt_reset_q), 16'(by_wdt & idle));
    cmd_irq = 1'h0;
    cyc(2);
  endtask : wake

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(82));
    {rst_n, cmd_save, cmd_sel, cmd_irq, irq_delay, wdt_en, wdt_timeout, bor_en, bor_trip} = '0;
    fail_safe_clock_monitor_en = 1'h0;
    {clk_switch_req, clk_switch_sel, stop_in_idle, periph_ext_clk, lvd_en, lvd_tap_sel, lvd_ext_sel} = '0;
    {lvd_tap_below, low_voltage_external_input, lvd_flag_clr} = '0;
    cfg_clk_src = 3'($urandom);
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    cyc(1);
    chk(16'(clk_src_q), 16'(cfg_clk_src));
    clk_switch_sel = ~cfg_clk_src;
    clk_switch_req = 1'h1;
    cyc(1);
    clk_switch_req = 1'h0;
    chk(16'(clk_src_q), 16'(clk_switch_sel));
    wdt_timeout = 1'h1;
    cyc(1);
    wdt_timeout = 1'h0;
    chk(16'(wdt_reset_q), 16'h1);
    // pending irq cancels a power-save request issued beside it
    cmd_irq = 1'h1;
    cyc(2);
    cmd_sel  = 1'($urandom);
    cmd_save = 1'h1;
    cyc(1);
    cmd_save = 1'h0;
    cyc(3);
    chk(16'(power_state_q), 16'(pmc_pkg::STATE_CODE_RUN));
    cmd_irq = 1'h0;
    cyc(2);
    // every mode, wake source and watchdog setting
    for (int i = 0; i < 8; i++) begin
      wdt_en         = 1'(i >> 2);
      {fail_safe_clock_monitor_en, bor_en, bor_trip} = 3'($urandom);
      stop_in_idle   = 8'($urandom);
      periph_ext_clk = 8'($urandom);
      cyc(2);
      enter(1'(i));
      chk(16'(bor_active_q), 16'(bor_en));
      chk(16'(bor_reset_q), 16'(bor_en & bor_trip));
      old_src        = clk_src_q;
      clk_switch_sel = ~old_src;
      clk_switch_req = 1'h1;
      cyc(1);
      clk_switch_req = 1'h0;
      cyc(1);
      chk(16'(clk_src_q), 16'(old_src));
      wake(1'(i >> 1), 1'(i));
    end
    // detector keeps flagging in sleep, over all taps and the external pin
    lvd_en = 1'h1;
    enter(1'h0);
    for (int t = 0; t < pmc_pkg::LVD_TAPS; t++) begin
      lvd_tap_sel   = 4'(t);
      lvd_tap_below = 16'($urandom) & ~(16'h1 << t);
      cyc(3);
      chk(16'(lvd_flag_q), 16'h0);
      lvd_tap_below[t] = 1'h1;
      cyc(2);
      chk(16'(lvd_flag_q), 16'h1);
      lvd_tap_below = 16'h0;
      lvd_flag_clr  = 1'h1;
      cyc(1);
      lvd_flag_clr  = 1'h0;
      cyc(1);
      chk(16'(lvd_flag_q), 16'h0);
    end
    lvd_ext_sel   = 1'h1;
    lvd_tap_below = 16'hFFFF;
    cyc(3);
    chk(16'(lvd_flag_q), 16'h0);
    low_voltage_external_input = 1'h1;
    cyc(2);
    chk(16'(lvd_flag_q), 16'h1);
    chk(16'(lvd_active_q), 16'h1);
    // clear held while the pin still reads low: the set must win
    lvd_flag_clr = 1'h1;
    cyc(1);
    chk(16'(lvd_flag_q), 16'h1);
    lvd_en       = 1'h0;
    cyc(1);
    lvd_flag_clr = 1'h0;
    cyc(2);
    chk(16'(lvd_flag_q), 16'h0);
    chk(16'(lvd_active_q), 16'h0);
    wake(1'h0, 1'h0);
    // second reset in mid-run picks up new configuration bits
    cfg_clk_src = 3'($urandom);
    rst_n       = 1'h0;
    cyc(2);
    rst_n = 1'h1;
    cyc(1);
    chk(16'(clk_src_q), 16'(cfg_clk_src));
    chk(16'(exp_q.size()), 16'h0);
    tally_and_finish();
  end
endmodule : tb
